// [hdl/nvw_cfg.svh]
// constants for the nonvolatile wiper access block
// Overview of operation
// (R01) Master writes START, address with write bit, location, data, STOP.
// (R02) A written value reaches the wiper once its data byte is acknowledged.
// (R03) Nonvolatile commit of written bytes starts only after the STOP.
// (R04) Repeated START after a write skips the nonvolatile cycle and delay.
// (R05) A write burst fills one 8-location page, address advancing per byte.
// (R06) Bursts over eight bytes keep only the final eight bytes; the code NACKs data bytes past the 16th (buffer full).
// (R07) Page write address wraps to the page start, never the next page.
// (R08) Own slave address is not acknowledged during the nonvolatile cycle.
// (R09) Master polls the address or waits the write time after a write.
// (R10) Reads return data at the internal address counter.
// (R11) Single read: START, address with read bit, byte, NACK, STOP.
// (R12) Master acks wanted bytes, NACKs the last; device keeps supplying bytes.
// (R13) Read address counter increments per byte, wrapping FFh to 00h.
// (R14) Random read: dummy write of location, repeated START, then read.
// (R15) Update off: initial value at power-up, then location 00h sets wiper.
// (R16) Auto update: each conversion picks an index, unsigned output to wiper.
// (R17) Auto update with adder: signed output plus initial value to wiper.
// (R18) Manual wiper, no adder: write to 09h loads wiper directly.
// (R19) Manual wiper with adder: write to 09h loads output plus initial value.
// (R20) Index override: write to 08h picks entry, unsigned output to wiper.
// (R21) Index override with adder: entry plus initial value goes to wiper.
// (R22) Foreign slave address: ignore the bus until the next START.
// (R23) First byte after a write address loads the address counter.
// (R24) Table entries unsigned 8-bit without adder, signed 7-bit with it.
// (R25) Signed sum is clamped to 0..127 rather than wrapping.
// (R26) Busy flag held for a counted nonvolatile cycle, gates address ack.
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH

`define NVW_ADDR_BASE       5'h0A
`define NVW_LOC_WIPER_DIR   8'h00
`define NVW_LOC_INDEX       8'h08
`define NVW_LOC_WIPER       8'h09
`define NVW_LOC_TABLE       8'h80
`define NVW_WIPER_RESET     7'h00
`define NVW_WIPER_MAX       7'h7F
`define NVW_FIFO_WIDTH      16
`define NVW_FIFO_DEPTH      16
`define NVW_CLK_PERIOD_NS   4
`define NVW_NV_WRITE_TIME_US 10
`define NVW_NV_WRITE_CYC    ((`NVW_NV_WRITE_TIME_US * 1000 + \
    `NVW_CLK_PERIOD_NS - 1) / `NVW_CLK_PERIOD_NS)

`endif

// [hdl/nvw_pkg.sv]
// types shared by the nonvolatile wiper access block
package nvw_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_WR   = 3'b010,
        ST_ACK  = 3'b011,
        ST_RD   = 3'b100,
        ST_MACK = 3'b101
    } nvw_state_e;
    typedef logic [7:0] nvw_byte_t;
endpackage

// [hdl/nvw_fifo.sv]
// buffer between accepted write bytes and the nonvolatile commit port
`timescale 1ns/1ps
module nvw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count
    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rp_q];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    // storage
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wp_q] <= in_data_in;
    end

    // pointers and count, flush drops everything held
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else if (flush_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [hdl/nvw_wiper.sv]
// wiper value from table output and initial value
`timescale 1ns/1ps
`include "nvw_cfg.svh"
module nvw_wiper (
    input  wire logic       adder_in,
    input  wire logic [7:0] table_output_in,
    input  wire logic [6:0] initial_wiper_value_in,
    output logic [6:0]      wiper_out
);
    logic [8:0] sum;

    // signed 7-bit entry plus initial value, clamped to range
    always_comb
    begin
        sum = {2'b00, initial_wiper_value_in}
            + {{2{table_output_in[6]}}, table_output_in[6:0]};
        if (adder_in)                                 // see R24
        begin
            if (sum[8])
                wiper_out = 7'h00;                    // see R25
            else if (sum[7])
                wiper_out = `NVW_WIPER_MAX;           // see R25
            else
                wiper_out = sum[6:0];
        end
        else if (table_output_in[7])
            wiper_out = `NVW_WIPER_MAX;               // see R24
        else
            wiper_out = table_output_in[6:0];
    end
endmodule

// [hdl/nvw_top.sv]
// i2c slave access, page write, nonvolatile cycle and wiper control
`timescale 1ns/1ps
`include "nvw_cfg.svh"
module nvw_top #(
    parameter int NV_CYC = `NVW_NV_WRITE_CYC
) (
    input  wire logic            ref_clk_in,
    input  wire logic            resetn_in,
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe_out,
    input  wire logic [1:0]      addr_pin_in,
    input  wire logic            update_mode_in,
    input  wire logic            adder_mode_in,
    input  wire logic            manual_wiper_in,
    input  wire logic            index_override_in,
    input  wire logic [6:0]      initial_wiper_value_in,
    input  wire logic            temp_index_valid_in,
    input  wire nvw_pkg::nvw_byte_t temp_index_in,
    output logic [6:0]           wiper_out,
    output nvw_pkg::nvw_byte_t   table_output_out,
    output logic                 nv_busy_out,
    output logic                 nv_wr_valid_out,
    output nvw_pkg::nvw_byte_t   nv_wr_addr_out,
    output nvw_pkg::nvw_byte_t   nv_wr_data_out
);
    import nvw_pkg::*;

    nvw_byte_t  mem_q [256];
    logic       scl_m_q, scl_s_q, scl_p_q;
    logic       sda_m_q, sda_s_q, sda_p_q;
    nvw_state_e st_q;
    logic [3:0] bit_q;
    nvw_byte_t  sh_q;
    nvw_byte_t  ptr_q;
    logic       rw_q;
    logic       first_q;
    logic       nack_q;
    logic       oe_q;
    logic       wrote_q;
    logic       busy_q;
    logic [15:0] cnt_q;
    logic       nv_valid_q;
    nvw_byte_t  nv_addr_q;
    nvw_byte_t  nv_data_q;
    logic [1:0] apin_m_q, apin_s_q;
    nvw_byte_t  tout_q;
    logic       apply_q;
    logic       init_q;
    logic [6:0] wiper_q;
    logic       scl_rise, scl_fall, start_ev, stop_ev;
    logic       addr_hit, wr_evt, rd_load, flush;
    logic       f_in_ready, f_out_valid, f_out_ready;
    logic [15:0] f_out_data;
    nvw_byte_t  rd_byte;
    nvw_byte_t  tbl_idx;
    logic       tbl_load;
    logic [6:0] calc;

    // advance within the current 8-location page only
    function automatic nvw_byte_t page_next(input nvw_byte_t a);
        page_next = {a[7:3], a[2:0] + 3'h1};
    endfunction

    // two-flop synchronisers plus one history stage for edge finding
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            apin_m_q <= 2'b00;
            apin_s_q <= 2'b00;
        end
        else
        begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            apin_m_q <= addr_pin_in;                  // address pins are pins
            apin_s_q <= apin_m_q;
        end
    end

    // bus events and transfer decisions
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign addr_hit = (sh_q[7:1] == {`NVW_ADDR_BASE, apin_s_q});
    assign wr_evt   = scl_fall & (st_q == ST_WR) & (bit_q == 4'h8)
                    & ~first_q & f_in_ready;
    assign rd_load  = scl_fall & (((st_q == ST_ACK) & rw_q)
                    | ((st_q == ST_MACK) & ~nack_q));
    assign rd_byte  = mem_q[ptr_q];                   // see R10
    assign flush    = start_ev & wrote_q;             // see R04

    // byte engine: address, location, data and read bits
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_q    <= ST_IDLE;
            bit_q   <= 4'h0;
            sh_q    <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            first_q <= 1'b0;
            nack_q  <= 1'b0;
            oe_q    <= 1'b0;
        end
        else if (start_ev)
        begin
            st_q  <= ST_DEV;
            bit_q <= 4'h0;
            oe_q  <= 1'b0;
        end
        else if (stop_ev)
        begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
        end
        else if (scl_rise)
        begin
            if ((st_q == ST_DEV || st_q == ST_WR) && bit_q != 4'h8)
            begin
                sh_q  <= {sh_q[6:0], sda_s_q};
                bit_q <= bit_q + 4'h1;
            end
            if (st_q == ST_MACK)
                nack_q <= sda_s_q;                    // see R12
        end
        else if (scl_fall)
        begin
            unique case (st_q)
                ST_IDLE: ;
                ST_DEV:
                    if (bit_q == 4'h8)
                    begin
                        if (addr_hit && !busy_q)      // see R08, R26, R09
                        begin
                            oe_q    <= 1'b1;
                            rw_q    <= sh_q[0];
                            first_q <= 1'b1;
                            st_q    <= ST_ACK;
                        end
                        else
                            st_q <= ST_IDLE;          // see R22
                    end
                ST_WR:
                    if (bit_q == 4'h8)
                    begin
                        if (first_q)
                        begin
                            ptr_q   <= sh_q;          // see R23, R14
                            first_q <= 1'b0;
                            oe_q    <= 1'b1;
                            st_q    <= ST_ACK;
                        end
                        else if (f_in_ready)
                        begin
                            ptr_q <= page_next(ptr_q); // see R05, R07
                            oe_q  <= 1'b1;
                            st_q  <= ST_ACK;
                        end
                        else
                            st_q <= ST_IDLE;          // buffer full: nack
                    end
                ST_ACK:
                    if (!rw_q)
                    begin
                        oe_q  <= 1'b0;
                        bit_q <= 4'h0;
                        st_q  <= ST_WR;
                    end
                ST_RD:
                    if (bit_q == 4'h8)
                    begin
                        oe_q <= 1'b0;
                        st_q <= ST_MACK;
                    end
                    else
                    begin
                        oe_q  <= ~sh_q[7];
                        sh_q  <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                    end
                ST_MACK:
                    if (nack_q)
                        st_q <= ST_IDLE;              // see R11, R12
                default:
                    st_q <= ST_IDLE;
            endcase
            // first bit of the next read byte goes out on this fall
            if (rd_load)
            begin
                oe_q  <= ~rd_byte[7];
                sh_q  <= {rd_byte[6:0], 1'b0};
                bit_q <= 4'h1;
                ptr_q <= ptr_q + 8'h01;               // see R13
                st_q  <= ST_RD;
            end
        end
    end

    // volatile store: data lands at once, last write per location wins
    always_ff @(posedge ref_clk_in)
    begin
        if (wr_evt)
            mem_q[ptr_q] <= sh_q;                     // see R02, R06
    end

    // write tracking and the counted nonvolatile cycle
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wrote_q <= 1'b0;
            busy_q  <= 1'b0;
            cnt_q   <= 16'h0000;
        end
        else
        begin
            if (wr_evt)
                wrote_q <= 1'b1;
            else if (start_ev || stop_ev)
                wrote_q <= 1'b0;
            if (stop_ev && wrote_q)
            begin
                busy_q <= 1'b1;                       // see R03, R26
                cnt_q  <= NV_CYC[15:0];
            end
            else if (busy_q)
            begin
                if (cnt_q != 16'h0000)
                    cnt_q <= cnt_q - 16'h0001;
                else if (!f_out_valid)
                    busy_q <= 1'b0;
            end
        end
    end

    // commit port drains the buffer only while the cycle runs
    assign f_out_ready = busy_q;
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            nv_valid_q <= 1'b0;
            nv_addr_q  <= 8'h00;
            nv_data_q  <= 8'h00;
        end
        else
        begin
            nv_valid_q <= busy_q & f_out_valid;       // see R06
            nv_addr_q  <= f_out_data[15:8];
            nv_data_q  <= f_out_data[7:0];
        end
    end

    nvw_fifo #(
        .WIDTH (`NVW_FIFO_WIDTH),
        .DEPTH (`NVW_FIFO_DEPTH)
    ) i_nvw_fifo (
        .clk_in        (ref_clk_in),
        .resetn_in     (resetn_in),
        .flush_in      (flush),
        .in_valid_in   (wr_evt),
        .in_ready_out  (f_in_ready),
        .in_data_in    ({ptr_q, sh_q}),
        .out_valid_out (f_out_valid),
        .out_ready_in  (f_out_ready),
        .out_data_out  (f_out_data)
    );

    // table index selection: conversion or host override
    assign tbl_load = update_mode_in & ~manual_wiper_in
        & (index_override_in
            ? (wr_evt & (ptr_q == `NVW_LOC_INDEX))    // see R20, R21
            : temp_index_valid_in);                   // see R16, R17
    assign tbl_idx = index_override_in ? sh_q : temp_index_in;

    // table output register and the apply strobe behind it
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tout_q  <= 8'h00;
            apply_q <= 1'b0;
        end
        else
        begin
            apply_q <= tbl_load;
            if (tbl_load)
            begin
                tout_q <= mem_q[`NVW_LOC_TABLE + tbl_idx];
            end
        end
    end

    nvw_wiper i_nvw_wiper (
        .adder_in               (adder_mode_in),
        .table_output_in        (tout_q),
        .initial_wiper_value_in (initial_wiper_value_in),
        .wiper_out              (calc)
    );

    // wiper position
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            init_q  <= 1'b1;
            wiper_q <= `NVW_WIPER_RESET;
        end
        else
        begin
            init_q <= 1'b0;
            if (init_q)
                wiper_q <= initial_wiper_value_in;    // see R15
            else if (!update_mode_in && wr_evt
                     && ptr_q == `NVW_LOC_WIPER_DIR)
                wiper_q <= sh_q[6:0];                 // see R15, R02
            else if (update_mode_in && manual_wiper_in && wr_evt
                     && ptr_q == `NVW_LOC_WIPER)
                wiper_q <= adder_mode_in ? calc       // see R19
                                         : sh_q[6:0]; // see R18
            else if (apply_q)
                wiper_q <= calc;                      // see R16, R17
        end
    end

    // outputs
    assign sda_out          = 1'b0;
    assign sda_oe_out       = oe_q;
    assign wiper_out        = wiper_q;
    assign table_output_out = tout_q;
    assign nv_busy_out      = busy_q;
    assign nv_wr_valid_out  = nv_valid_q;
    assign nv_wr_addr_out   = nv_addr_q;
    assign nv_wr_data_out   = nv_data_q;

    // checks
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    chk_busy_no_ack: assert property ( // see R08
        scl_fall && st_q == ST_DEV && bit_q == 4'h8 && busy_q
        |=> !oe_q && st_q == ST_IDLE) else $error("acked while busy");
    chk_nv_after_stop: assert property ( // see R03
        stop_ev && wrote_q |=> busy_q ##1 busy_q)
        else $error("no nv cycle after stop");
    chk_rstart_skip: assert property ( // see R04
        start_ev && wrote_q && !busy_q |=> !busy_q && !f_out_valid)
        else $error("repeated start did not skip");
    chk_page_wrap: assert property ( // see R07
        wr_evt |=> ptr_q[7:3] == $past(ptr_q[7:3])
        && ptr_q[2:0] == $past(ptr_q[2:0]) + 3'h1)
        else $error("page address left its page");
    chk_read_wrap: assert property ( // see R13
        rd_load |=> ptr_q == $past(ptr_q) + 8'h01
        && oe_q == ~$past(rd_byte[7])) else $error("read counter wrong");
    chk_memaddr_load: assert property ( // see R23
        scl_fall && st_q == ST_WR && bit_q == 4'h8 && first_q
        |=> ptr_q == $past(sh_q)) else $error("location not loaded");
    chk_foreign_addr: assert property ( // see R22
        scl_fall && st_q == ST_DEV && bit_q == 4'h8 && !addr_hit
        |=> st_q == ST_IDLE && !oe_q) else $error("foreign address taken");
    chk_direct_wiper: assert property ( // see R15
        !init_q && !update_mode_in && wr_evt
        && ptr_q == `NVW_LOC_WIPER_DIR |=> wiper_q == $past(sh_q[6:0]))
        else $error("direct wiper write lost");
    chk_manual_wiper: assert property ( // see R18
        !init_q && update_mode_in && manual_wiper_in && !adder_mode_in
        && wr_evt && ptr_q == `NVW_LOC_WIPER |=> wiper_q == $past(sh_q[6:0]))
        else $error("manual wiper write lost");
    chk_table_apply: assert property ( // see R16
        tbl_load |=> apply_q ##1 (wiper_q == $past(calc) || $past(wr_evt)))
        else $error("table output not applied");

    cov_nv_cycle: cover property ($rose(busy_q) ##[1:1000] nv_valid_q);
    cov_read_seq: cover property (rd_load ##[1:300] rd_load);
    cov_rstart:   cover property (flush);
    cov_apply:    cover property (apply_q && adder_mode_in);
endmodule

// [tb/nvw_master.sv]
// bus master model driving the link clock and data line
`timescale 1ns/1ps
module nvw_master (
    output logic      scl_out,
    output logic      sda_oe_out,
    input  wire logic sda_in
);
    // bus idle: clock stands high, data released
    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // start or repeated start: data falls while clock high
    task automatic start();
        sda_oe_out = 1'b0;
        #8 scl_out = 1'b1;
        #8 sda_oe_out = 1'b1;
        #8 scl_out = 1'b0;
        #8;
    endtask
    // stop: data rises while clock high, clock then stands still
    task automatic stop();
        sda_oe_out = 1'b1;
        #8 scl_out = 1'b1;
        #8 sda_oe_out = 1'b0;
        #16;
    endtask
    // one bit, driven in clock low, sampled in clock high
    task automatic bit_x(input logic b, output logic s);
        sda_oe_out = ~b;
        #8 scl_out = 1'b1;
        #8 s = sda_in;
        #8 scl_out = 1'b0;
        #8;
    endtask
    // byte out msb first, then sample the slave acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    // byte in msb first, then ack to continue or nack to end
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(~ack, s);
    endtask
endmodule

// [tb/nvw_top_bench.sv]
// self-checking bench for the nonvolatile wiper access block
`timescale 1ns/1ps
`include "nvw_cfg.svh"
module nvw_top_bench;
    import nvw_pkg::*;
    logic        clk, rstn, m_scl, m_oe, sda_oe, sda_o, busy, cval, ak;
    logic        upd, add, man, ovr, tv;
    logic [6:0]  iv, wip;
    logic [1:0]  apin;
    nvw_byte_t   ti, tout, cadr, cdat, et;
    nvw_byte_t   mem [256];
    nvw_byte_t   wd [16];
    logic [15:0] cq [$];
    logic [15:0] eq [$];
    logic [31:0] seed;
    int          n_fail, cmp_count;
    wire         sda = ~(m_oe | (sda_oe & ~sda_o)); // pulled up
    nvw_top #(.NV_CYC(200)) i_nvw_top (
        .ref_clk_in             (clk),
        .resetn_in              (rstn),
        .scl_in                 (m_scl),
        .sda_in                 (sda),
        .sda_out                (sda_o),
        .sda_oe_out             (sda_oe),
        .addr_pin_in            (apin),
        .update_mode_in         (upd),
        .adder_mode_in          (add),
        .manual_wiper_in        (man),
        .index_override_in      (ovr),
        .initial_wiper_value_in (iv),
        .temp_index_valid_in    (tv),
        .temp_index_in          (ti),
        .wiper_out              (wip),
        .table_output_out       (tout),
        .nv_busy_out            (busy),
        .nv_wr_valid_out        (cval),
        .nv_wr_addr_out         (cadr),
        .nv_wr_data_out         (cdat)
    );
    nvw_master i_nvw_master (
        .scl_out    (m_scl),
        .sda_oe_out (m_oe),
        .sda_in     (sda)
    );
    // block clock, 4 ns
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog against a hung bus
    initial
    begin
        #200000;
        n_fail++;
        conclude();
    end
    // collect commit pulses
    always @(negedge clk) if (cval) cq.push_back({cadr, cdat});
    // xorshift source
    function automatic nvw_byte_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // expected wiper from table entry, adder mode and initial value
    function automatic logic [6:0] exp_w(input logic a, input nvw_byte_t t);
        int s;
        if (!a) return (t > 127) ? 7'h7F : t[6:0];
        s = int'(iv) + int'($signed(t[6:0]));
        return (s < 0) ? 7'h00 : (s > 127) ? 7'h7F : 7'(s);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // write n bytes of wd from loc, end in stop or repeated start
    task automatic wr(input nvw_byte_t loc, input int n, input bit sr);
        nvw_byte_t a;
        a = loc;
        i_nvw_master.start();
        i_nvw_master.wr_byte({`NVW_ADDR_BASE, apin, 1'b0}, ak);
        chk("address ack", 16'h1, 16'(ak));
        i_nvw_master.wr_byte(loc, ak);
        chk("location ack", 16'h1, 16'(ak));
        for (int i = 0; i < n; i++)
        begin
            i_nvw_master.wr_byte(wd[i], ak);
            chk("data ack", 16'h1, 16'(ak));
            mem[a] = wd[i];
            eq.push_back({a, wd[i]});
            a[2:0] = a[2:0] + 3'h1;
        end
        if (!sr) chk("busy early", 16'h0, 16'(busy));
        if (sr) i_nvw_master.start();
        else i_nvw_master.stop();
        if (sr) eq.delete();
    endtask
    // acknowledge polling until the commit cycle ends
    task automatic poll();
        int k;
        k = 0;
        do
        begin
            i_nvw_master.start();
            i_nvw_master.wr_byte({`NVW_ADDR_BASE, apin, 1'b0}, ak);
            i_nvw_master.stop();
            k++;
        end while (!ak && k < 60);
        chk("poll ack", 16'h1, 16'(ak));
        chk("polled while busy", 16'h1, 16'(k > 1));
        chk("commit count", 16'(eq.size()), 16'(cq.size()));
        foreach (eq[i]) chk("commit", eq[i], cq[i]);
        eq.delete();
        cq.delete();
    endtask
    // dummy write of loc, repeated start, read n bytes
    task automatic rd(input nvw_byte_t loc, input int n);
        nvw_byte_t d;
        wr(loc, 0, 1);
        i_nvw_master.wr_byte({`NVW_ADDR_BASE, apin, 1'b1}, ak);
        chk("read address ack", 16'h1, 16'(ak));
        for (int i = 0; i < n; i++)
        begin
            i_nvw_master.rd_byte(i < n - 1, d);
            chk("read", 16'(mem[loc]), 16'(d));
            loc++;
        end
        i_nvw_master.stop();
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        seed = 32'h0000B661;
        {n_fail, cmp_count} = '0;
        {rstn, upd, add, man, ovr, tv, ti} = '0;
        iv = 7'(rnd());
        apin = 2'(rnd());
        repeat (6) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("wiper at reset", 16'(iv), 16'(wip));
        wd[0] = rnd();
        wr(`NVW_LOC_WIPER_DIR, 1, 1);
        chk("wiper direct", 16'(wd[0][6:0]), 16'(wip));
        i_nvw_master.stop();
        repeat (10) @(posedge clk);
        #1 chk("no cycle", 16'h0, 16'(busy + cq.size()));
        $display("done: direct write");
        foreach (wd[i]) wd[i] = rnd();
        wr(8'h13, 10, 0);
        poll();
        rd(8'h10, 8);
        wr(8'hFE, 2, 1);
        rd(8'hFE, 3);
        $display("done: page write and reads");
        i_nvw_master.start();
        i_nvw_master.wr_byte({`NVW_ADDR_BASE, ~apin, 1'b0}, ak);
        chk("foreign", 16'h0, 16'(ak));
        i_nvw_master.wr_byte(8'h00, ak);
        chk("ignored", 16'h0, 16'(ak));
        i_nvw_master.stop();
        $display("done: foreign address");
        foreach (wd[i]) wd[i] = rnd();
        wr(`NVW_LOC_TABLE, 8, 0);
        poll();
        for (int j = 0; j < 24; j++)
        begin
            @(posedge clk);
            #1 upd = 1'b1;
            add = rnd() > 8'h7F;
            iv = 7'(rnd());
            man = (j % 3 == 2);
            ovr = (j % 3 == 1);
            wd[0] = rnd() & 8'h07;
            if (j % 3 == 0)
            begin
                ti = wd[0];
                tv = 1'b1;
                @(posedge clk);
                #1 tv = 1'b0;
                repeat (3) @(posedge clk);
            end
            else
            begin
                if (j % 3 == 2) wd[0] = rnd();
                wr(j % 3 == 1 ? `NVW_LOC_INDEX : `NVW_LOC_WIPER, 1, 1);
                i_nvw_master.stop();
            end
            if (j % 3 < 2) et = mem[`NVW_LOC_TABLE + wd[0]];
            #1 chk("table output", 16'(et), 16'(tout));
            chk("wiper", 16'((j % 3 == 2 && !add) ? wd[0][6:0] :
                exp_w(add, et)), 16'(wip));
        end
        $display("done: wiper modes");
        conclude();
    end
endmodule
